// ===== design/veiu_consts.svh
// Constants of the vectored external interrupt unit
`ifndef VEIU_CONSTS_SVH
`define VEIU_CONSTS_SVH
`define VEIU_VEC_RESET   5'h00
`define VEIU_VEC_EXT     5'h01
`define VEIU_VEC_PC0     5'h02
`define VEIU_VEC_PC1     5'h03
`define VEIU_VEC_WDT     5'h04
`define VEIU_VEC_T1CAPT  5'h05
`define VEIU_VEC_T1CMPA  5'h06
`define VEIU_VEC_T1CMPB  5'h07
`define VEIU_VEC_T1OVF   5'h08
`define VEIU_VEC_T0CMPA  5'h09
`define VEIU_VEC_T0CMPB  5'h0a
`define VEIU_VEC_T0OVF   5'h0b
`define VEIU_VEC_ACOMP   5'h0c
`define VEIU_VEC_CONV    5'h0d
`define VEIU_VEC_EERDY   5'h0e
`define VEIU_VEC_SERSTA  5'h0f
`define VEIU_VEC_SEROVF  5'h10
`define VEIU_OFF_MCUCTL  12'h000
`define VEIU_OFF_ENABLE  12'h004
`define VEIU_OFF_FLAGS   12'h008
`define VEIU_OFF_MASKHI  12'h00c
`define VEIU_OFF_MASKLO  12'h010
`define VEIU_OFF_STATUS  12'h014
`define VEIU_BIT_EXT     6
`define VEIU_BIT_PC1     5
`define VEIU_BIT_PC0     4
`define VEIU_SENSE_LOW   2'h0
`define VEIU_SENSE_ANY   2'h1
`define VEIU_SENSE_FALL  2'h2
`define VEIU_SENSE_RISE  2'h3
`define VEIU_RST_SENSE   2'h0
`define VEIU_RST_MASKLO  8'h00
`define VEIU_RST_MASKHI  4'h0
`define VEIU_PC_W        12
`define VEIU_PC_LO       8
`define VEIU_NSRC        16
`endif

// ===== design/veiu_pkg.sv
// Types of the vectored external interrupt unit
package veiu_pkg;
  typedef logic [1:0] veiu_sense_t;
  typedef logic [4:0] veiu_vec_t;
  typedef logic [3:0] veiu_idx_t;
  typedef enum logic {VEIU_BOOT, VEIU_RUN} veiu_state_t;
endpackage : veiu_pkg

// ===== design/veiu_det_if.sv
// Carrier between the controller and the pin detector
`timescale 1ns/1ps
`include "veiu_consts.svh"
interface veiu_det_if;
  logic                        ext_pin;
  logic [`VEIU_PC_W-1:0]       pc_pins;
  logic [`VEIU_PC_LO-1:0]      mask_low;
  logic [`VEIU_PC_W-`VEIU_PC_LO-1:0] mask_high;
  veiu_pkg::veiu_sense_t       sense;
  logic                        io_en;
  logic                        ext_set;
  logic                        pc0_set;
  logic                        pc1_set;
  logic                        level_low;
  modport det (input ext_pin, pc_pins, mask_low, mask_high, sense, io_en,
               output ext_set, pc0_set, pc1_set, level_low);
  modport ctl (output ext_pin, pc_pins, mask_low, mask_high, sense, io_en,
               input ext_set, pc0_set, pc1_set, level_low);
endinterface : veiu_det_if

// ===== design/veiu_detect.sv
// Pin change, edge and level detector
`timescale 1ns/1ps
`include "veiu_consts.svh"
module veiu_detect (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  veiu_det_if.det   dif
);
  logic [`VEIU_PC_W-1:0] prev_pc_ff;
  logic [`VEIU_PC_W-1:0] nxt_prev_pc;
  logic                  prev_ext_ff;
  logic                  nxt_prev_ext;
  logic                  primed_ff;
  logic                  nxt_primed;
  logic [`VEIU_PC_W-1:0] toggle;
  logic                  rise;
  logic                  fall;

  always_comb begin
    // Pin change path runs regardless of the I/O clock gate
    nxt_prev_pc  = dif.pc_pins; // [R11]
    nxt_primed   = 1'b1;
    toggle       = primed_ff ? (dif.pc_pins ^ prev_pc_ff) : '0;
    dif.pc0_set  = |(toggle[`VEIU_PC_LO-1:0] & dif.mask_low); // [R8] [R10] [R7]
    dif.pc1_set  = |(toggle[`VEIU_PC_W-1:`VEIU_PC_LO] & dif.mask_high); // [R9] [R10]
    // Edge sampling only advances while the I/O clock runs
    nxt_prev_ext = dif.io_en ? dif.ext_pin : prev_ext_ff; // [R14]
    rise         = dif.io_en & primed_ff & dif.ext_pin & ~prev_ext_ff; // [R20]
    fall         = dif.io_en & primed_ff & ~dif.ext_pin & prev_ext_ff; // [R20]
    case (dif.sense) // [R19] [R12]
      `VEIU_SENSE_ANY:  dif.ext_set = rise | fall;
      `VEIU_SENSE_FALL: dif.ext_set = fall;
      `VEIU_SENSE_RISE: dif.ext_set = rise;
      default:          dif.ext_set = 1'b0;
    endcase
    dif.level_low = ~dif.ext_pin; // [R15] [R7]
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prev_pc_ff  <= '0;
      prev_ext_ff <= 1'b0;
      primed_ff   <= 1'b0;
    end else begin
      prev_pc_ff  <= nxt_prev_pc;
      prev_ext_ff <= nxt_prev_ext;
      primed_ff   <= nxt_primed;
    end
  end
endmodule : veiu_detect

// ===== design/veiu_top.sv
// Vectored external interrupt unit with APB register file
//
// Functional notes
// [R1] Any reset fetches vector 0x0000
// [R2] External, group0, group1 vectors at 0x0001..0x0003
// [R3] 16-bit timer vectors at 0x0005..0x0008
// [R4] 8-bit timer vectors at 0x0009..0x000B
// [R5] Remaining sources take the leftover slots in order
// [R6] Unused vectors may hold code if never enabled
// [R7] Interrupts fire even when pins drive outputs
// [R8] Group0 requests on any enabled input 7..0 toggle
// [R9] Group1 requests on any enabled input 11..8 toggle
// [R10] Per-pin masks select contributing inputs
// [R11] Pin change detection works without I/O clock
// [R12] External pin triggers on edge or level
// [R13] Low level requests while pin stays low
// [R14] Edge detection needs I/O clock running
// [R15] Low level detection works without I/O clock
// [R16] I/O clock stops in all sleep except idle
// [R17] Wake level must outlast start-up delay
// [R18] Level gone before start-up: no level request
// [R19] Sense codes: low, change, falling, rising
// [R20] Pulses over one clock reliably request
// [R21] Flags clear on vector taken or written one
`timescale 1ns/1ps
`include "veiu_consts.svh"
module veiu_top #(
  parameter int PC_WIDTH = `VEIU_PC_W,
  parameter int PC_LOW   = `VEIU_PC_LO
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_PIN,
  input  wire logic [11:0] PC_PINS,
  input  wire logic [12:0] SRC_REQ,
  input  wire logic        CORE_IEN,
  input  wire logic        CORE_ACK,
  input  wire logic        CORE_SLEEP,
  input  wire logic        SLEEP_IDLE,
  output logic             IRQ_REQ,
  output logic      [4:0]  IRQ_VECTOR,
  output logic             WAKE
);
  generate
    if (PC_WIDTH != `VEIU_PC_W || PC_LOW != `VEIU_PC_LO) begin : g_chk
      $error("veiu_top: pin change widths must be 12 inputs split at 8");
    end
  endgenerate

  veiu_det_if dif ();

  veiu_pkg::veiu_sense_t      sense_ff;
  veiu_pkg::veiu_sense_t      nxt_sense;
  logic                       en_ext_ff;
  logic                       nxt_en_ext;
  logic                       en_pc0_ff;
  logic                       nxt_en_pc0;
  logic                       en_pc1_ff;
  logic                       nxt_en_pc1;
  logic                       flag_ext_ff;
  logic                       nxt_flag_ext;
  logic                       flag_pc0_ff;
  logic                       nxt_flag_pc0;
  logic                       flag_pc1_ff;
  logic                       nxt_flag_pc1;
  logic [7:0]                 mask_lo_ff;
  logic [7:0]                 nxt_mask_lo;
  logic [3:0]                 mask_hi_ff;
  logic [3:0]                 nxt_mask_hi;
  logic [31:0]                prdata_ff;
  logic [31:0]                nxt_prdata;
  logic                       slverr_ff;
  logic                       nxt_slverr;
  veiu_pkg::veiu_state_t      state_ff;
  veiu_pkg::veiu_state_t      nxt_state;
  logic                       req_ff;
  logic                       nxt_req;
  veiu_pkg::veiu_vec_t        vec_ff;
  veiu_pkg::veiu_vec_t        nxt_vec;
  logic                       wake_ff;
  logic                       nxt_wake;
  logic                       setup;
  logic                       wr;
  logic                       level_mode;
  logic                       taken;
  logic [`VEIU_NSRC-1:0]      pend;
  veiu_pkg::veiu_idx_t        win;
  logic                       mapped;
  logic [31:0]                rd_val;

  // Slot address of each source, lowest index is highest priority
  function automatic veiu_pkg::veiu_vec_t veiu_vec_of(input veiu_pkg::veiu_idx_t idx);
    case (idx)
      4'h0:    veiu_vec_of = `VEIU_VEC_EXT;    // [R2]
      4'h1:    veiu_vec_of = `VEIU_VEC_PC0;    // [R2]
      4'h2:    veiu_vec_of = `VEIU_VEC_PC1;    // [R2]
      4'h3:    veiu_vec_of = `VEIU_VEC_WDT;    // [R5]
      4'h4:    veiu_vec_of = `VEIU_VEC_T1CAPT; // [R3]
      4'h5:    veiu_vec_of = `VEIU_VEC_T1CMPA; // [R3]
      4'h6:    veiu_vec_of = `VEIU_VEC_T1CMPB; // [R3]
      4'h7:    veiu_vec_of = `VEIU_VEC_T1OVF;  // [R3]
      4'h8:    veiu_vec_of = `VEIU_VEC_T0CMPA; // [R4]
      4'h9:    veiu_vec_of = `VEIU_VEC_T0CMPB; // [R4]
      4'ha:    veiu_vec_of = `VEIU_VEC_T0OVF;  // [R4]
      4'hb:    veiu_vec_of = `VEIU_VEC_ACOMP;  // [R5]
      4'hc:    veiu_vec_of = `VEIU_VEC_CONV;   // [R5]
      4'hd:    veiu_vec_of = `VEIU_VEC_EERDY;  // [R5]
      4'he:    veiu_vec_of = `VEIU_VEC_SERSTA; // [R5]
      default: veiu_vec_of = `VEIU_VEC_SEROVF; // [R5]
    endcase
  endfunction : veiu_vec_of

  // True when the vector just taken belongs to the given slot
  function automatic logic veiu_took(input logic tk, input veiu_pkg::veiu_vec_t v,
                                     input veiu_pkg::veiu_vec_t slot);
    veiu_took = tk & (v == slot);
  endfunction : veiu_took

  assign dif.ext_pin   = EXT_PIN;
  assign dif.pc_pins   = PC_PINS;
  assign dif.mask_low  = mask_lo_ff;
  assign dif.mask_high = mask_hi_ff;
  assign dif.sense     = sense_ff;
  assign dif.io_en     = ~CORE_SLEEP | SLEEP_IDLE; // [R16]

  veiu_detect u_detect (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .dif     (dif)
  );

  assign setup      = PSEL & ~PENABLE;
  assign wr         = PSEL & PENABLE & PWRITE;
  assign level_mode = (sense_ff == `VEIU_SENSE_LOW);
  assign taken      = CORE_ACK & req_ff & (state_ff == veiu_pkg::VEIU_RUN);

  // Register read mux and address decode
  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    case (PADDR)
      `VEIU_OFF_MCUCTL: rd_val[1:0] = sense_ff;
      `VEIU_OFF_ENABLE: begin
        rd_val[`VEIU_BIT_EXT] = en_ext_ff;
        rd_val[`VEIU_BIT_PC1] = en_pc1_ff;
        rd_val[`VEIU_BIT_PC0] = en_pc0_ff;
      end
      `VEIU_OFF_FLAGS: begin
        rd_val[`VEIU_BIT_EXT] = flag_ext_ff;
        rd_val[`VEIU_BIT_PC1] = flag_pc1_ff;
        rd_val[`VEIU_BIT_PC0] = flag_pc0_ff;
      end
      `VEIU_OFF_MASKHI: rd_val[3:0] = mask_hi_ff;
      `VEIU_OFF_MASKLO: rd_val[7:0] = mask_lo_ff;
      `VEIU_OFF_STATUS: rd_val = {11'h000, PC_PINS, EXT_PIN, req_ff, vec_ff, 2'h0};
      default:          mapped = 1'b0;
    endcase
  end

  // Register file next state
  always_comb begin
    nxt_sense   = sense_ff;
    nxt_en_ext  = en_ext_ff;
    nxt_en_pc0  = en_pc0_ff;
    nxt_en_pc1  = en_pc1_ff;
    nxt_mask_lo = mask_lo_ff;
    nxt_mask_hi = mask_hi_ff;
    nxt_prdata  = prdata_ff;
    nxt_slverr  = slverr_ff;
    if (setup) begin
      nxt_prdata = PWRITE ? 32'h0000_0000 : rd_val;
      nxt_slverr = ~mapped;
    end
    if (wr) begin
      case (PADDR)
        `VEIU_OFF_MCUCTL: nxt_sense = PWDATA[1:0]; // [R12]
        `VEIU_OFF_ENABLE: begin
          nxt_en_ext = PWDATA[`VEIU_BIT_EXT];
          nxt_en_pc1 = PWDATA[`VEIU_BIT_PC1];
          nxt_en_pc0 = PWDATA[`VEIU_BIT_PC0];
        end
        `VEIU_OFF_MASKHI: nxt_mask_hi = PWDATA[3:0]; // [R10]
        `VEIU_OFF_MASKLO: nxt_mask_lo = PWDATA[7:0]; // [R10]
        default:          nxt_mask_lo = mask_lo_ff;
      endcase
    end
  end

  // Flags: hardware set wins over software or vector clear
  always_comb begin
    logic w1c;
    w1c          = wr & (PADDR == `VEIU_OFF_FLAGS);
    nxt_flag_ext = dif.ext_set | (flag_ext_ff & ~(w1c & PWDATA[`VEIU_BIT_EXT])
                   & ~veiu_took(taken, vec_ff, `VEIU_VEC_EXT)); // [R21]
    nxt_flag_pc0 = dif.pc0_set | (flag_pc0_ff & ~(w1c & PWDATA[`VEIU_BIT_PC0])
                   & ~veiu_took(taken, vec_ff, `VEIU_VEC_PC0)); // [R21] [R8]
    nxt_flag_pc1 = dif.pc1_set | (flag_pc1_ff & ~(w1c & PWDATA[`VEIU_BIT_PC1])
                   & ~veiu_took(taken, vec_ff, `VEIU_VEC_PC1)); // [R21] [R9]
    // Level mode keeps the external flag clear
    if (level_mode) begin
      nxt_flag_ext = 1'b0;
    end
  end

  // Pending sources and priority pick
  always_comb begin
    // Level request follows the live pin, so a vanished level makes none
    pend[0] = en_ext_ff & (level_mode ? dif.level_low : flag_ext_ff); // [R13] [R18]
    pend[1] = en_pc0_ff & flag_pc0_ff;
    pend[2] = en_pc1_ff & flag_pc1_ff;
    pend[`VEIU_NSRC-1:3] = SRC_REQ;
    win = 4'hf;
    for (int i = `VEIU_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = 4'(i);
      end
    end
  end

  // Vector sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_req   = 1'b0;
    nxt_vec   = `VEIU_VEC_RESET;
    nxt_wake  = (en_ext_ff & level_mode & dif.level_low) // [R15]
              | (en_pc0_ff & (dif.pc0_set | flag_pc0_ff)) // [R11]
              | (en_pc1_ff & (dif.pc1_set | flag_pc1_ff))
              | (en_ext_ff & flag_ext_ff);
    case (state_ff)
      veiu_pkg::VEIU_BOOT: begin
        nxt_req = ~CORE_ACK; // [R1]
        nxt_vec = `VEIU_VEC_RESET; // [R1]
        if (CORE_ACK) begin
          nxt_state = veiu_pkg::VEIU_RUN;
        end
      end
      veiu_pkg::VEIU_RUN: begin
        // A taken vector drops the request for one cycle to let flags settle
        nxt_req = CORE_IEN & (|pend) & ~taken;
        nxt_vec = (|pend) ? veiu_vec_of(win) : vec_ff;
      end
      default: begin
        nxt_state = veiu_pkg::VEIU_BOOT;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sense_ff    <= `VEIU_RST_SENSE;
      en_ext_ff   <= 1'b0;
      en_pc0_ff   <= 1'b0;
      en_pc1_ff   <= 1'b0;
      flag_ext_ff <= 1'b0;
      flag_pc0_ff <= 1'b0;
      flag_pc1_ff <= 1'b0;
      mask_lo_ff  <= `VEIU_RST_MASKLO;
      mask_hi_ff  <= `VEIU_RST_MASKHI;
      prdata_ff   <= 32'h0000_0000;
      slverr_ff   <= 1'b0;
      state_ff    <= veiu_pkg::VEIU_BOOT;
      req_ff      <= 1'b1;
      vec_ff      <= `VEIU_VEC_RESET;
      wake_ff     <= 1'b0;
    end else begin
      sense_ff    <= nxt_sense;
      en_ext_ff   <= nxt_en_ext;
      en_pc0_ff   <= nxt_en_pc0;
      en_pc1_ff   <= nxt_en_pc1;
      flag_ext_ff <= nxt_flag_ext;
      flag_pc0_ff <= nxt_flag_pc0;
      flag_pc1_ff <= nxt_flag_pc1;
      mask_lo_ff  <= nxt_mask_lo;
      mask_hi_ff  <= nxt_mask_hi;
      prdata_ff   <= nxt_prdata;
      slverr_ff   <= nxt_slverr;
      state_ff    <= nxt_state;
      req_ff      <= nxt_req;
      vec_ff      <= nxt_vec;
      wake_ff     <= nxt_wake;
    end
  end

  assign PRDATA     = prdata_ff;
  assign PREADY     = PSEL & PENABLE;
  assign PSLVERR    = PSEL & PENABLE & slverr_ff;
  assign IRQ_REQ    = req_ff;
  assign IRQ_VECTOR = vec_ff;
  assign WAKE       = wake_ff;
endmodule : veiu_top

// ===== tb/veiu_checker.sv
// Port checker of the vectored external interrupt unit
`timescale 1ns/1ps
module veiu_checker (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [12:0] SRC_REQ,
  input wire logic        CORE_IEN,
  input wire logic        CORE_ACK,
  input wire logic        IRQ_REQ,
  input wire logic [4:0]  IRQ_VECTOR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  sequence s_boot;
    IRQ_REQ && IRQ_VECTOR == 5'h00;
  endsequence
  a_pready_access: assert property (PREADY == (PSEL && PENABLE))
    else $error("pready off the access phase");
  a_slverr_phase: assert property (PSLVERR |-> s_access)
    else $error("pslverr outside access");
  a_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
    else $error("read data moved without setup");
  a_reset_vector: assert property ($fell(SYS_RST) |-> s_boot)
    else $error("no reset vector after reset");
  a_boot_hold: assert property (s_boot ##0 !CORE_ACK |=> s_boot)
    else $error("reset vector dropped before ack");
  a_ack_drop: assert property (IRQ_REQ && CORE_ACK |=> !IRQ_REQ)
    else $error("request stays after ack");
  a_src_request: assert property (
    CORE_IEN && SRC_REQ != 13'h0 && !IRQ_REQ && !CORE_ACK |=> IRQ_REQ)
    else $error("pending source not requested");
  a_src_priority: assert property (
    $rose(IRQ_REQ) && IRQ_VECTOR >= 5'h04 |->
    (($past(SRC_REQ) >> (IRQ_VECTOR - 5'h04)) & 13'h1) == 13'h1 &&
    ($past(SRC_REQ) & ((13'h1 << (IRQ_VECTOR - 5'h04)) - 13'h1)) == 13'h0)
    else $error("source vector wrong");
endmodule : veiu_checker
bind veiu_top veiu_checker u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_REQ(SRC_REQ),
  .CORE_IEN(CORE_IEN), .CORE_ACK(CORE_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR)
);

// ===== tb/veiu_core_model.sv
// Behavioural core that takes interrupt vectors
`timescale 1ns/1ps
module veiu_core_model (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       irq_req,
  input  wire logic [4:0] irq_vector,
  input  wire logic       take_en,
  input  wire logic [3:0] ack_delay,
  output logic            core_ack,
  output logic      [4:0] taken_vec,
  output logic      [7:0] taken_cnt
);
  logic       ack_ff;
  logic [3:0] wait_ff;
  assign core_ack = ack_ff;
  // Vectors are fetched only while the unit requests one
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_ff    <= 1'b0;
      wait_ff   <= 4'h0;
      taken_vec <= 5'h00;
      taken_cnt <= 8'h00;
    end else if (ack_ff) begin
      ack_ff  <= 1'b0;
      wait_ff <= 4'h0;
      // An acknowledge that meets no request is ignored by the unit as well
      if (irq_req) begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end else if (irq_req && take_en) begin
      ack_ff  <= (wait_ff >= ack_delay);
      wait_ff <= wait_ff + 4'h1;
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule : veiu_core_model

// ===== tb/veiu_bench.sv
// Testbench of the vectored external interrupt unit
`timescale 1ns/1ps
module veiu_bench;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, CORE_ACK, IRQ_REQ, WAKE;
  logic        EXT_PIN = 1'b1;
  logic [11:0] PC_PINS = 12'h000;
  logic [12:0] SRC_REQ = 13'h0;
  logic        CORE_IEN = 1'b1;
  logic        CORE_SLEEP = 1'b0;
  logic        SLEEP_IDLE = 1'b0;
  logic        take_en = 1'b1;
  logic [3:0]  ack_dly = 4'h2;
  logic [4:0]  IRQ_VECTOR, taken_vec;
  logic [7:0]  taken_cnt;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors = 0;
  int          n_checks = 0;
  always #20 CLK = ~CLK;
  veiu_top u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EXT_PIN(EXT_PIN), .PC_PINS(PC_PINS), .SRC_REQ(SRC_REQ),
    .CORE_IEN(CORE_IEN), .CORE_ACK(CORE_ACK), .CORE_SLEEP(CORE_SLEEP),
    .SLEEP_IDLE(SLEEP_IDLE), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .WAKE(WAKE));
  veiu_core_model u_core (.CLK(CLK), .SYS_RST(SYS_RST), .irq_req(IRQ_REQ),
    .irq_vector(IRQ_VECTOR), .take_en(take_en), .ack_delay(ack_dly),
    .core_ack(CORE_ACK), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // PREADY ends the wait for the slave; only the watchdog ends a wait that never sees it
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask : rd
  task automatic take_wait(input logic [7:0] b);
    for (int n = 0; n < 30 && taken_cnt === b; n++) @(posedge CLK);
    cyc(2);
  endtask : take_wait
  task automatic ext_step(input logic [1:0] s, input logic lvl, input logic exp);
    logic [7:0] b;
    apb(1'b1, 12'h000, {30'h0, s});
    b = taken_cnt;
    EXT_PIN <= lvl;
    take_wait(b);
    chk("ext takes", {24'h0, b} + {31'h0, exp}, {24'h0, taken_cnt});
    if (exp) chk("ext vector", 32'h1, {27'h0, taken_vec});
  endtask : ext_step
  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    cyc(20000);
    num_errors++;
    results();
  end
  initial begin
    cyc(10);
    SYS_RST <= 1'b0;
    take_wait(8'h0);
    chk("reset vector", 32'h0, {27'h0, taken_vec});
    chk("reset takes", 32'h1, {24'h0, taken_cnt});
    for (int a = 0; a <= 16; a += 4) rd("reset reg", a[11:0], 32'h0);
    apb(1'b1, 12'h018, 32'hffffffff);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    rd("unmapped read", 12'h018, 32'h0);
    apb(1'b1, 12'h010, 32'h8);
    apb(1'b1, 12'h004, 32'h10);
    rd("mask low", 12'h010, 32'h8);
    PC_PINS <= 12'h004;
    cyc(6);
    chk("masked pin", 32'h1, {24'h0, taken_cnt});
    PC_PINS <= 12'h00c;
    take_wait(8'h1);
    chk("group0 vector", 32'h2, {27'h0, taken_vec});
    rd("flags taken", 12'h008, 32'h0);
    take_en <= 1'b0;
    CORE_SLEEP <= 1'b1;
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h004, 32'h20);
    PC_PINS <= 12'h10c;
    cyc(3);
    chk("pc wake", 32'h1, {31'h0, WAKE});
    chk("group1 vector", 32'h3, {27'h0, IRQ_VECTOR});
    rd("group1 flag", 12'h008, 32'h20);
    rd("status", 12'h014, 32'h0002198c);
    CORE_SLEEP <= 1'b0;
    take_en <= 1'b1;
    ack_dly <= 4'h0;
    take_wait(8'h2);
    apb(1'b1, 12'h004, 32'h40);
    ext_step(2'h2, 1'b0, 1'b1);
    ext_step(2'h2, 1'b1, 1'b0);
    ext_step(2'h3, 1'b0, 1'b0);
    ext_step(2'h3, 1'b1, 1'b1);
    ext_step(2'h1, 1'b0, 1'b1);
    ext_step(2'h1, 1'b1, 1'b1);
    take_en <= 1'b0;
    apb(1'b1, 12'h000, 32'h2);
    CORE_SLEEP <= 1'b1;
    EXT_PIN <= 1'b0;
    cyc(3);
    EXT_PIN <= 1'b1;
    cyc(3);
    chk("gated wake", 32'h0, {31'h0, WAKE});
    CORE_SLEEP <= 1'b0;
    cyc(4);
    chk("gated edge", 32'h0, {31'h0, IRQ_REQ});
    SLEEP_IDLE <= 1'b1;
    CORE_SLEEP <= 1'b1;
    EXT_PIN <= 1'b0;
    cyc(4);
    chk("idle edge", 32'h1, {31'h0, IRQ_REQ});
    CORE_SLEEP <= 1'b0;
    SLEEP_IDLE <= 1'b0;
    apb(1'b1, 12'h008, 32'h40);
    cyc(2);
    chk("flag cleared", 32'h0, {31'h0, IRQ_REQ});
    EXT_PIN <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    CORE_SLEEP <= 1'b1;
    EXT_PIN <= 1'b0;
    cyc(3);
    chk("level wake", 32'h1, {31'h0, WAKE});
    CORE_SLEEP <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge CLK);
      chk("level request", 32'h1, {31'h0, IRQ_REQ});
    end
    rd("level flag", 12'h008, 32'h0);
    EXT_PIN <= 1'b1;
    cyc(3);
    chk("level gone", 32'h0, {31'h0, IRQ_REQ});
    apb(1'b1, 12'h004, 32'h0);
    for (int k = 0; k < 13; k++) begin
      SRC_REQ <= (13'h1 << k) | 13'h1000;
      cyc(3);
      chk("source vector", 32'h4 + k, {27'h0, IRQ_VECTOR});
      SRC_REQ <= 13'h0;
      cyc(3);
    end
    results();
  end
endmodule : veiu_bench
